// [logic/timer16_capture_compare.sv]
// Chosen here: the register addresses and the AHB-Lite register port.
`default_nettype none
module timer16_capture_compare
  import timer16_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic count_clk_in,
  input wire logic edge_input_a_in,
  input wire logic edge_input_b_in,
  input wire logic hsel_in,
  input wire logic [7:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic match_irq_a_out,
  output logic match_irq_b_out
);
  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [15:0] counter_reg;
  logic [15:0] match_a_reg;
  logic [15:0] match_b_reg;
  logic [1:0] run_mode_reg;
  logic wrap_reg;
  logic [2:0] capctl_reg;
  logic [3:0] edge_sel_reg;
  logic cclk_d_reg;
  logic in_a_d_reg;
  logic in_b_d_reg;
  logic [31:0] rdata_reg;
  logic irq_a_reg;
  logic irq_b_reg;

  wire bus_go = hsel_in && hready_in && htrans_in[1];
  wire rd_go = bus_go && !hwrite_in;
  wire wr_mode = wr_pend_reg && (wr_addr_reg == OFS_MODE);
  wire wr_capctl = wr_pend_reg && (wr_addr_reg == OFS_CAPCTL);
  wire wr_edge = wr_pend_reg && (wr_addr_reg == OFS_EDGE);
  wire wr_a = wr_pend_reg && (wr_addr_reg == OFS_MATCH_A);
  wire wr_b = wr_pend_reg && (wr_addr_reg == OFS_MATCH_B);
  // Zero wait states, always OKAY
  assign hreadyout_out = 1'b1;
  assign hresp_out = 1'b0;
  assign hrdata_out = rdata_reg;
  assign match_irq_a_out = irq_a_reg;
  assign match_irq_b_out = irq_b_reg;

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= bus_go && hwrite_in;
      wr_addr_reg <= haddr_in;
    end
  end

  // ----------------------------------------
  // Edge detection on count clock and pins
  // ----------------------------------------
  wire run_mode_t run_mode = run_mode_t'(run_mode_reg);
  wire running = (run_mode != RUN_STOP);
  wire read_freeze = rd_go && (haddr_in == OFS_COUNTER);
  wire tick = count_clk_in && !cclk_d_reg && running && !read_freeze;
  wire a_rise = edge_input_a_in && !in_a_d_reg;
  wire a_fall = !edge_input_a_in && in_a_d_reg;
  wire b_rise = edge_input_b_in && !in_b_d_reg;
  wire b_fall = !edge_input_b_in && in_b_d_reg;
  wire [1:0] es_a = edge_sel_reg[1:0];
  wire [1:0] es_b = edge_sel_reg[3:2];
  // Valid edge of input A
  wire a_valid = (es_a == EDGE_FALL) ? a_fall :
                 (es_a == EDGE_RISE) ? a_rise :
                 (es_a == EDGE_BOTH) ? (a_rise || a_fall) : 1'b0;
  // opposite edge of A, none for both-edge code
  wire a_opposite = (es_a == EDGE_FALL) ? a_rise :
                    (es_a == EDGE_RISE) ? a_fall : 1'b0;
  wire b_valid = (es_b == EDGE_FALL) ? b_fall :
                 (es_b == EDGE_RISE) ? b_rise :
                 (es_b == EDGE_BOTH) ? (b_rise || b_fall) : 1'b0;
  wire cap_a_trig = capctl_reg[A_CAP_BIT] && running &&
                    (capctl_reg[A_SRC_BIT] ? a_opposite : b_valid);
  // B capture only from A valid edge
  wire cap_b_trig = capctl_reg[B_CAP_BIT] && running && a_valid;

  // ----------------------------------------
  // Compare and counter next value
  // ----------------------------------------
  // A compare on equality, zero after wrap
  wire match_a = running && !capctl_reg[A_CAP_BIT] && (counter_reg == match_a_reg);
  wire match_b = running && !capctl_reg[B_CAP_BIT] && (counter_reg == match_b_reg);
  wire wrap_evt = tick && (counter_reg == COUNTER_MAX);
  logic [15:0] counter_next;
  always_comb begin
    counter_next = counter_reg;
    case (run_mode)
      RUN_STOP: counter_next = COUNTER_RESET;
      RUN_EDGE_CLEAR: begin
        if (a_valid) begin
          counter_next = COUNTER_RESET;
        end else if (tick) begin
          counter_next = counter_reg + 16'h0001;
        end
      end
      RUN_MATCH_CLEAR: begin
        if (tick && counter_reg == match_a_reg) begin
          counter_next = COUNTER_RESET;
        end else if (tick) begin
          counter_next = counter_reg + 16'h0001;
        end
      end
      RUN_FREE: begin
        if (tick) begin
          counter_next = counter_reg + 16'h0001;
        end
      end
      default: counter_next = COUNTER_RESET;
    endcase
  end

  // Counter, control and flags
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      counter_reg <= COUNTER_RESET;
      run_mode_reg <= 2'b00;
      capctl_reg <= 3'b000;
      edge_sel_reg <= 4'h0;
      cclk_d_reg <= 1'b0;
      in_a_d_reg <= 1'b0;
      in_b_d_reg <= 1'b0;
    end else begin
      counter_reg <= counter_next;
      cclk_d_reg <= count_clk_in;
      in_a_d_reg <= edge_input_a_in;
      in_b_d_reg <= edge_input_b_in;
      if (wr_mode) begin
        run_mode_reg <= hwdata_in[RUN_HI_BIT:RUN_LO_BIT];
      end
      if (wr_capctl) begin
        capctl_reg <= hwdata_in[2:0];
      end
      if (wr_edge) begin
        edge_sel_reg <= hwdata_in[7:4];
      end
    end
  end

  // wrap flag, set wins over clear
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wrap_reg <= 1'b0;
    end else if (wrap_evt) begin
      wrap_reg <= 1'b1;
    end else if (wr_mode) begin
      wrap_reg <= hwdata_in[WRAP_BIT];
    end
  end

  // Match pulses, one per counter value
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_a_reg <= 1'b0;
      irq_b_reg <= 1'b0;
    end else begin
      irq_a_reg <= match_a && tick;
      irq_b_reg <= match_b && tick;
    end
  end

  // ----------------------------------------
  // Match/capture registers, no reset
  // ----------------------------------------
  // no reset; capture beats write
  always_ff @(posedge sys_clk_in) begin
    if (cap_a_trig) begin
      match_a_reg <= counter_reg;
    end else if (wr_a) begin
      match_a_reg <= hwdata_in[15:0];
    end
    if (cap_b_trig) begin
      match_b_reg <= counter_reg;
    end else if (wr_b) begin
      match_b_reg <= hwdata_in[15:0];
    end
  end

  // Read data registered in address phase
  logic [31:0] rd_mux;
  always_comb begin
    case (haddr_in)
      OFS_COUNTER: rd_mux = {16'h0000, counter_reg};
      OFS_MATCH_A: rd_mux = {16'h0000, match_a_reg};
      OFS_MATCH_B: rd_mux = {16'h0000, match_b_reg};
      OFS_MODE: rd_mux = {28'h000_0000, run_mode_reg, 1'b0, wrap_reg};
      OFS_CAPCTL: rd_mux = {29'h0000_0000, capctl_reg};
      OFS_EDGE: rd_mux = {24'h00_0000, edge_sel_reg, 4'h0};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_reg <= rd_mux;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_stop_zero;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (run_mode == RUN_STOP) |=> counter_reg == 16'h0000;
  endproperty
  a_stop_zero: assert property (p_stop_zero) else $error("counter not zero in stop");
  property p_count;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (run_mode == RUN_FREE && tick && !wr_mode) |=> counter_reg == $past(counter_reg) + 16'h0001;
  endproperty
  a_count: assert property (p_count) else $error("counter did not increment");
  property p_freeze;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (read_freeze && run_mode == RUN_FREE) |=> $stable(counter_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("counter moved during read");
  property p_edge_clr;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
      (run_mode == RUN_EDGE_CLEAR && a_valid) |=> counter_reg == 16'h0000;
  endproperty
  a_edge_clr: assert property (p_edge_clr) else $error("edge clear missed");
  property p_irq_a;
    @(posedge sys_clk_in) disable iff (!rst_n_in) (match_a && tick) |=> match_irq_a_out;
  endproperty
  a_irq_a: assert property (p_irq_a) else $error("match a irq missing");
  property p_irq_b;
    @(posedge sys_clk_in) disable iff (!rst_n_in) match_irq_b_out |-> $past(match_b);
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("spurious match b irq");
  property p_wrap;
    @(posedge sys_clk_in) disable iff (!rst_n_in) wrap_evt |=> wrap_reg && counter_reg == 16'h0000;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag not set");
  property p_cap_b;
    @(posedge sys_clk_in) disable iff (!rst_n_in) cap_b_trig |=> match_b_reg == $past(counter_reg);
  endproperty
  a_cap_b: assert property (p_cap_b) else $error("capture b wrong");
  c_wrap: cover property (@(posedge sys_clk_in) wrap_evt);
  c_cap_a: cover property (@(posedge sys_clk_in) cap_a_trig);
  c_irq_a: cover property (@(posedge sys_clk_in) match_irq_a_out);
endmodule : timer16_capture_compare
`default_nettype wire

// [logic/timer16_pkg.sv]
// What this block does
// - 16-bit read-only counter, counts selected clock
// - Counter read briefly freezes counting
// - Clear on reset or run mode stop
// - Edge clear mode zeroes on valid edge
// - Match clear mode zeroes on A match
// - Bit 0 selects A compare or capture
// - A compare raises match_irq_a on equality
// - Input A edge code sets capture edges
// - Input B edge code sets A capture
// - Match registers not initialised by reset
// - Zero A matches after counter wraps
// - Lowered A value waits through overflow
// - Bit 2 selects B compare or capture
// - B compare raises match_irq_b on equality
// - B captures only from input A edges
// - Zero B matches after wrap
// - Lowered B value waits through overflow
// - Run mode: stop, free, edge clear, match clear
// - Trigger source picks A capture edge
// - Wrap flag set on counter overflow
`default_nettype none
package timer16_pkg;
  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_COUNTER = 8'h00;
  localparam logic [7:0] OFS_MATCH_A = 8'h04;
  localparam logic [7:0] OFS_MATCH_B = 8'h08;
  localparam logic [7:0] OFS_MODE = 8'h0C;
  localparam logic [7:0] OFS_CAPCTL = 8'h10;
  localparam logic [7:0] OFS_EDGE = 8'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int WRAP_BIT = 0;
  localparam int RUN_LO_BIT = 2;
  localparam int RUN_HI_BIT = 3;
  localparam int A_CAP_BIT = 0;
  localparam int A_SRC_BIT = 1;
  localparam int B_CAP_BIT = 2;
  localparam int ES_A_LO_BIT = 4;
  localparam int ES_B_LO_BIT = 6;
  localparam logic [15:0] COUNTER_RESET = 16'h0000;
  localparam logic [15:0] COUNTER_MAX = 16'hFFFF;
  // Edge codes and run modes
  localparam logic [1:0] EDGE_FALL = 2'b00;
  localparam logic [1:0] EDGE_RISE = 2'b01;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  typedef enum logic [1:0] {
    RUN_STOP = 2'b00,
    RUN_FREE = 2'b01,
    RUN_EDGE_CLEAR = 2'b10,
    RUN_MATCH_CLEAR = 2'b11
  } run_mode_t;
endpackage : timer16_pkg
`default_nettype wire

// [dv/pulse_source_model.sv]
`default_nettype none
module pulse_source_model (
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic level_a_in,
  input wire logic level_b_in,
  output logic edge_input_a_out,
  output logic edge_input_b_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] hold_reg;
  // ----------------------------------------
  // Pulse shaping
  // ----------------------------------------
  // minimum pulse width
  // Both levels are held for at least 13 system clocks, so the timer samples each level many times
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hold_reg <= 5'h00;
      edge_input_a_out <= 1'b0;
      edge_input_b_out <= 1'b0;
    end else if (hold_reg != 5'h00) begin
      hold_reg <= hold_reg - 5'h01;
    end else if ({level_a_in, level_b_in} != {edge_input_a_out, edge_input_b_out}) begin
      edge_input_a_out <= level_a_in;
      edge_input_b_out <= level_b_in;
      hold_reg <= 5'h0C;
    end
  end
endmodule : pulse_source_model
`default_nettype wire

// [dv/testbench.sv]
`default_nettype none
module testbench;
  import timer16_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk, rst_n, count_clk, lvl_a, lvl_b, pin_a, pin_b, hsel, hwrite, hreadyout;
  logic hresp, irq_a, irq_b;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  int failures, cmp_count, cycles, irq_a_n, irq_b_n;
  // ----------------------------------------
  // Design and pulse sources
  // ----------------------------------------
  timer16_capture_compare u_timer16_capture_compare (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .count_clk_in(count_clk), .edge_input_a_in(pin_a), .edge_input_b_in(pin_b),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout), .hrdata_out(hrdata),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .match_irq_a_out(irq_a),
    .match_irq_b_out(irq_b));
  pulse_source_model u_pulse_source_model (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
    .level_a_in(lvl_a), .level_b_in(lvl_b), .edge_input_a_out(pin_a),
    .edge_input_b_out(pin_b));
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Interrupt pulse tally and hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (irq_a === 1'b1) irq_a_n <= irq_a_n + 1;
    if (irq_b === 1'b1) irq_b_n <= irq_b_n + 1;
    if (cycles == 5000) begin
      failures = failures + 1;
      conclude();
    end
  end
  // ----------------------------------------
  // Bus, pin and check tasks
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [7:0] adr, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= adr;
    hwrite <= wr;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask : bus
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] adr, input logic [15:0] d);
    logic [31:0] r;
    bus(1'b1, adr, {16'h0000, d}, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] adr, input logic [15:0] exp);
    logic [31:0] r;
    bus(1'b0, adr, 32'h0000_0000, r);
    chk(r, {16'h0000, exp});
  endtask : rd_chk
  // Ticks kept well clear of bus reads, so no count is dropped
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      count_clk <= 1'b1;
      repeat (2) @(posedge sys_clk);
      count_clk <= 1'b0;
      @(posedge sys_clk);
    end
  endtask : tick
  task automatic pins(input logic a, input logic b);
    lvl_a <= a;
    lvl_b <= b;
    repeat (20) @(posedge sys_clk);
  endtask : pins
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    {rst_n, count_clk, lvl_a, lvl_b, hsel, hwrite} = 6'h00;
    {failures, cmp_count, cycles, irq_a_n, irq_b_n} = '0;
    haddr = 8'h00;
    htrans = 2'b00;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd_chk(OFS_COUNTER, 16'h0000);
    rd_chk(OFS_MODE, 16'h0000);
    rd_chk(8'h40, 16'h0000);
    wr(OFS_COUNTER, 16'h1234);
    rd_chk(OFS_COUNTER, 16'h0000);
    $display("Test reset and read-only done");
    wr(OFS_MATCH_A, 16'h0005);
    wr(OFS_MATCH_B, 16'h0003);
    wr(OFS_MODE, 16'h0004);
    tick(6);
    rd_chk(OFS_COUNTER, 16'h0006);
    chk(irq_a_n, 32'h0000_0001);
    chk(irq_b_n, 32'h0000_0001);
    wr(OFS_MODE, 16'h0000);
    rd_chk(OFS_COUNTER, 16'h0000);
    $display("Test free run compare done");
    wr(OFS_MATCH_A, 16'h0003);
    wr(OFS_MODE, 16'h000C);
    tick(4);
    rd_chk(OFS_COUNTER, 16'h0000);
    tick(1);
    rd_chk(OFS_COUNTER, 16'h0001);
    chk(irq_a_n, 32'h0000_0002);
    wr(OFS_MODE, 16'h0000);
    $display("Test match clear done");
    wr(OFS_EDGE, 16'h0010);
    wr(OFS_MODE, 16'h0008);
    tick(6);
    pins(1'b1, 1'b0);
    rd_chk(OFS_COUNTER, 16'h0000);
    pins(1'b0, 1'b0);
    wr(OFS_MODE, 16'h0000);
    $display("Test edge clear done");
    // pin A stays an input here
    wr(OFS_CAPCTL, 16'h0005);
    wr(OFS_EDGE, 16'h0040);
    wr(OFS_MODE, 16'h0004);
    tick(7);
    pins(1'b0, 1'b1);
    tick(2);
    pins(1'b1, 1'b1);
    pins(1'b0, 1'b1);
    rd_chk(OFS_MATCH_A, 16'h0007);
    rd_chk(OFS_MATCH_B, 16'h0009);
    wr(OFS_CAPCTL, 16'h0007);
    tick(1);
    pins(1'b1, 1'b1);
    rd_chk(OFS_MATCH_A, 16'h000A);
    rd_chk(OFS_MATCH_B, 16'h0009);
    $display("Test capture done");
    conclude();
  end
endmodule : testbench
`default_nettype wire
